// ### logic/ums_pkg.sv
// Package: register map, field positions and carriers for the modem status flag block
package ums_pkg;

    // Register byte offsets (channel_status has no printed offset)
    localparam logic [7:0] UMS_OFF_CTRL = 8'h00;
    localparam logic [7:0] UMS_OFF_MODE = 8'h04;
    localparam logic [7:0] UMS_OFF_IER = 8'h08;
    localparam logic [7:0] UMS_OFF_IDR = 8'h0c;
    localparam logic [7:0] UMS_OFF_IMR = 8'h10;
    localparam logic [7:0] UMS_OFF_STATUS = 8'h14;
    localparam logic [7:0] UMS_OFF_THR = 8'h1c;
    localparam logic [7:0] UMS_OFF_EVT = 8'h20;

    // Status bit positions
    localparam int UMS_B_DSR = 21;
    localparam int UMS_B_RI = 20;
    localparam int UMS_B_CLEAR_TO_SEND_CHANGE_FLAG = 19;
    localparam int UMS_B_CARRIER_DETECT_CHANGE_FLAG = 18;
    localparam int UMS_B_DATA_SET_READY_CHANGE_FLAG = 17;
    localparam int UMS_B_RING_INDICATOR_CHANGE_FLAG = 16;
    localparam int UMS_B_NACK = 13;
    localparam int UMS_B_REPETITION_LIMIT_FLAG = 10;
    localparam int UMS_B_TXE = 9;

    // Control command register bits
    localparam int UMS_C_CLEAR_NON_ACK_COMMAND_BIT = 14;
    localparam int UMS_C_RSTREP_BIT = 15;

    // Mode register fields
    localparam int UMS_M_INH = 20;
    localparam int UMS_M_LIM = 21;
    localparam int UMS_M_MAXLO = 24;
    localparam int UMS_M_MAXW = 3;

    // Sticky event status bits set by hardware, plus the transmitter idle bit 9
    localparam logic [31:0] UMS_STICKY_MASK = 32'h000f_2600;
    localparam logic [31:0] UMS_RESET_ZERO = 32'h0000_0000;
    localparam logic [31:0] UMS_RESET_MODE = 32'h0000_0000;
    localparam logic [31:0] UMS_SLVERR_DATA = 32'h0000_0000;

    // Synchronised modem line levels
    typedef struct packed {
        logic cts;
        logic dcd;
        logic dsr;
        logic ri;
    } ums_modem_t;

    // Smart-card receive result strobes
    typedef struct packed {
        logic char_done;
        logic parity_err;
    } ums_rx_evt_t;

endpackage

// ### logic/ums_status.sv
// Module: modem status and smart-card flag logic behind an APB slave
//
// Functional notes
// RULE_01 - Status bit 21 mirrors data-set-ready level
// RULE_02 - Status bit 20 mirrors ring-indicator level
// RULE_03 - Bit 19 flags clear-to-send change, read-cleared
// RULE_04 - Bit 18 flags carrier-detect change, read-cleared
// RULE_05 - Bit 17 flags data-set-ready change, read-cleared
// RULE_06 - Bit 16 flags ring-indicator change, read-cleared
// RULE_07 - Bit 13 non-ack flag, cleared by command
// RULE_08 - Bit 10 repetition flag, cleared by command
// RULE_09 - Bit 9 transmitter idle, cleared on holding write
// RULE_10 - Limited mode counts errors, stops non-acks
// RULE_11 - Unlimited mode non-acks each parity error
// RULE_12 - Two-flop sync, one edge one flag
// RULE_13 - Change during read keeps flag set
//
// Overview
// The block holds the status side of one serial channel.
// Software reaches it over APB with single-word transfers.
// Every transfer has one setup cycle and one access cycle.
// No wait states are ever inserted by this slave.
// Ready, read data and slave error are registered outputs.
// They are computed from the setup cycle.
// They stand for exactly the one access cycle.
// Read data is zero outside the access cycle.
// An unmapped address answers with slave error and no effect.
//
// Register map
// Control at offset 0x00 is write-only and holds commands.
// Bit 14 clears the non-ack flag, bit 15 the repetition flag.
// Mode at offset 0x04 holds inhibit, limit and the max count.
// Enable at 0x08 sets mask bits, disable at 0x0c clears them.
// Mask at 0x10 can also be written whole and read back.
// Status at 0x14 is read-only; writes there are ignored.
// Holding register at 0x1c only restarts the busy timer.
// Event view at 0x20 shows sticky bits; a one written clears.
//
// Modem lines
// Each line passes two flip-flops before any logic reads it.
// A change is the second stage against its previous sample.
// Pulses shorter than one clock may be missed entirely.
// The change flag is set three edges after the pin moves.
// A status read clears only the change flags it reported.
// A change that lands while the read is in flight is kept.
// Data-set-ready and ring levels are read live, not stored.
//
// Smart-card side
// A parity error on a received character may cause a non-ack.
// The non-ack pulse and the sticky flag follow one edge later.
// Inhibit suppresses the pulse and the flag together.
// With limiting on, consecutive errors are counted.
// At the configured maximum the pulse stops, the flag rises.
// A clean character restarts the count from zero.
//
// Transmitter idle
// There is no real shifter; a timer models the busy time.
// A write to the holding register restarts that timer.
// The idle bit is rebuilt every cycle, so it is not W1C.
//
// Interrupt
// One level output, high while an unmasked sticky bit is set.
// It is built from next state so it rises with the flag.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module ums_status #(
    parameter int TX_IDLE_CYCLES = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ums_pkg::ums_modem_t modem_in,
    input wire ums_pkg::ums_rx_evt_t rx_evt,
    output logic nack_out,
    output logic irq
);
    import ums_pkg::*;

    initial begin
        if (TX_IDLE_CYCLES < 1 || TX_IDLE_CYCLES > 65535) begin
            $error("TX_IDLE_CYCLES out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    ums_modem_t sync1_r; // First stage, read only by second
    ums_modem_t sync2_r; // Second stage, safe level
    ums_modem_t prev_r; // Previous safe sample
    logic [31:0] status_r; // Sticky flags and idle flag
    logic [31:0] status_nxt;
    logic [31:0] mode_r; // Limit, inhibit and max count
    logic [31:0] imr_r; // Interrupt mask
    logic [31:0] imr_nxt;
    logic [2:0] rep_cnt_r; // Consecutive parity errors
    logic [2:0] rep_cnt_nxt;
    logic [15:0] tx_cnt_r; // Shift-out time of current character
    logic [15:0] tx_cnt_nxt;
    logic [31:0] prdata_nxt;
    logic nack_nxt;
    logic irq_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire access = psel && penable;
    wire wr_en = access && pwrite;
    wire rd_en = access && !pwrite;
    // Read data is prepared in setup so it stands with ready
    wire rd_setup = psel && !penable && !pwrite;
    wire hit_ctrl = paddr == UMS_OFF_CTRL;
    wire hit_mode = paddr == UMS_OFF_MODE;
    wire hit_ier = paddr == UMS_OFF_IER;
    wire hit_idr = paddr == UMS_OFF_IDR;
    wire hit_imr = paddr == UMS_OFF_IMR;
    wire hit_stat = paddr == UMS_OFF_STATUS;
    wire hit_thr = paddr == UMS_OFF_THR;
    wire hit_evt = paddr == UMS_OFF_EVT;
    wire mapped = hit_ctrl | hit_mode | hit_ier | hit_idr | hit_imr | hit_stat | hit_thr | hit_evt;
    wire stat_read = rd_en && hit_stat;
    wire cmd_wr = wr_en && hit_ctrl;
    wire thr_wr = wr_en && hit_thr;
    // Write-one-to-clear of the sticky bits through the event register
    wire [31:0] w1c = (wr_en && hit_evt) ? (pwdata & UMS_STICKY_MASK) : UMS_RESET_ZERO;

    ////////////////////////////////////////////////////////////////////////
    // Modem change detection

    wire [3:0] chg = sync2_r ^ prev_r; // RULE_12
    wire lim_en = mode_r[UMS_M_LIM];
    wire inh_en = mode_r[UMS_M_INH];
    wire [2:0] max_rep = mode_r[UMS_M_MAXLO +: UMS_M_MAXW];

    ////////////////////////////////////////////////////////////////////////
    // Smart-card non-acknowledge decision

    wire perr = rx_evt.char_done && rx_evt.parity_err;
    wire good = rx_evt.char_done && !rx_evt.parity_err;
    wire at_limit = rep_cnt_r >= max_rep;
    // Limited mode: non-ack while under the limit; at it, raise the flag
    wire send_nack = perr && !inh_en && !(lim_en && at_limit); // RULE_10 RULE_11
    wire hit_limit = perr && lim_en && at_limit; // RULE_10

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for counters

    always_comb begin
        rep_cnt_nxt = rep_cnt_r;
        if (good || !lim_en) begin
            rep_cnt_nxt = 3'h0; // Run broken by a clean character
        end else if (perr && !at_limit) begin
            rep_cnt_nxt = rep_cnt_r + 3'h1; // RULE_10
        end
    end

    always_comb begin
        tx_cnt_nxt = tx_cnt_r;
        if (thr_wr) begin
            tx_cnt_nxt = 16'(TX_IDLE_CYCLES);
        end else if (tx_cnt_r != 16'h0000) begin
            tx_cnt_nxt = tx_cnt_r - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status next value; sets are applied after clears so sets win

    always_comb begin
        status_nxt = status_r & ~w1c;
        // Only flags shown in the read data are cleared, so none is lost
        if (stat_read) begin
            status_nxt[UMS_B_CLEAR_TO_SEND_CHANGE_FLAG] = status_nxt[UMS_B_CLEAR_TO_SEND_CHANGE_FLAG] & ~prdata[UMS_B_CLEAR_TO_SEND_CHANGE_FLAG]; // RULE_03
            status_nxt[UMS_B_CARRIER_DETECT_CHANGE_FLAG] = status_nxt[UMS_B_CARRIER_DETECT_CHANGE_FLAG] & ~prdata[UMS_B_CARRIER_DETECT_CHANGE_FLAG]; // RULE_04
            status_nxt[UMS_B_DATA_SET_READY_CHANGE_FLAG] = status_nxt[UMS_B_DATA_SET_READY_CHANGE_FLAG] & ~prdata[UMS_B_DATA_SET_READY_CHANGE_FLAG]; // RULE_05
            status_nxt[UMS_B_RING_INDICATOR_CHANGE_FLAG] = status_nxt[UMS_B_RING_INDICATOR_CHANGE_FLAG] & ~prdata[UMS_B_RING_INDICATOR_CHANGE_FLAG]; // RULE_06
        end
        if (cmd_wr && pwdata[UMS_C_CLEAR_NON_ACK_COMMAND_BIT]) begin
            status_nxt[UMS_B_NACK] = 1'b0; // RULE_07
        end
        if (cmd_wr && pwdata[UMS_C_RSTREP_BIT]) begin
            status_nxt[UMS_B_REPETITION_LIMIT_FLAG] = 1'b0; // RULE_08
        end
        // Change seen during a read stays set
        if (chg[3]) begin
            status_nxt[UMS_B_CLEAR_TO_SEND_CHANGE_FLAG] = 1'b1; // RULE_03 RULE_13
        end
        if (chg[2]) begin
            status_nxt[UMS_B_CARRIER_DETECT_CHANGE_FLAG] = 1'b1; // RULE_04 RULE_13
        end
        if (chg[1]) begin
            status_nxt[UMS_B_DATA_SET_READY_CHANGE_FLAG] = 1'b1; // RULE_05 RULE_13
        end
        if (chg[0]) begin
            status_nxt[UMS_B_RING_INDICATOR_CHANGE_FLAG] = 1'b1; // RULE_06 RULE_13
        end
        if (send_nack) begin
            status_nxt[UMS_B_NACK] = 1'b1; // RULE_07
        end
        if (hit_limit) begin
            status_nxt[UMS_B_REPETITION_LIMIT_FLAG] = 1'b1; // RULE_08
        end
        // Idle unless a character is being shifted
        status_nxt[UMS_B_TXE] = !thr_wr && tx_cnt_nxt == 16'h0000; // RULE_09
        status_nxt[UMS_B_DSR] = 1'b0;
        status_nxt[UMS_B_RI] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; live images are inserted at read time

    wire [31:0] stat_view = status_r | ({31'h0, sync2_r.dsr} << UMS_B_DSR) // RULE_01
                                     | ({31'h0, sync2_r.ri} << UMS_B_RI); // RULE_02

    always_comb begin
        prdata_nxt = UMS_RESET_ZERO;
        if (rd_setup) begin
            unique case (1'b1)
                hit_mode: prdata_nxt = mode_r;
                hit_imr: prdata_nxt = imr_r;
                hit_stat: prdata_nxt = stat_view;
                hit_evt: prdata_nxt = status_r & UMS_STICKY_MASK;
                default: prdata_nxt = UMS_RESET_ZERO; // Write-only or unmapped
            endcase
        end
    end

    always_comb begin
        imr_nxt = imr_r;
        if (wr_en && hit_ier) begin
            imr_nxt = imr_r | (pwdata & UMS_STICKY_MASK);
        end else if (wr_en && hit_idr) begin
            imr_nxt = imr_r & ~pwdata;
        end else if (wr_en && hit_imr) begin
            imr_nxt = pwdata & UMS_STICKY_MASK;
        end
    end

    // Interrupt from the next status so it tracks flags without a lag
    assign irq_nxt = |(status_nxt & imr_nxt & UMS_STICKY_MASK);
    assign nack_nxt = send_nack; // RULE_11

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers; first stage feeds only the second

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end else begin
            sync1_r <= modem_in; // RULE_12
            sync2_r <= sync1_r; // RULE_12
            prev_r <= sync2_r; // RULE_12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= UMS_RESET_ZERO;
            mode_r <= UMS_RESET_MODE;
            imr_r <= UMS_RESET_ZERO;
            rep_cnt_r <= 3'h0;
            tx_cnt_r <= 16'h0000;
        end else begin
            status_r <= status_nxt;
            imr_r <= imr_nxt;
            rep_cnt_r <= rep_cnt_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            if (wr_en && hit_mode) begin
                mode_r <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all registered

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= UMS_RESET_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
            nack_out <= 1'b0;
            irq <= 1'b0;
        end else begin
            prdata <= prdata_nxt;
            pready <= psel && !penable; // Ready in the first access cycle
            pslverr <= psel && !penable && !mapped;
            nack_out <= nack_nxt;
            irq <= irq_nxt;
        end
    end

endmodule

// ### verification/ums_chk.sv
// Checker: bus timing, modem images, clear-to-send change flag, non-ack pulses
`timescale 1ns/1ps
module ums_chk
    import ums_pkg::*;
#(
    parameter int TX_IDLE_CYCLES = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire ums_pkg::ums_modem_t modem_in,
    input wire ums_pkg::ums_rx_evt_t rx_evt,
    input wire logic nack_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    // Status read completing now
    wire logic st_rd = pready && !pwrite && paddr == UMS_OFF_STATUS;
    // Decoded map
    wire logic mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20};
    ////////////////////////////////////////
    a_ready_access: assert property ((psel && !penable) ##1 (psel && penable) |-> pready)
        else $error("no ready in access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("slave error wrong for address");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_dsr_image: assert property ($stable(modem_in.dsr) [*4] ##0 st_rd |-> prdata[UMS_B_DSR] == modem_in.dsr)
        else $error("dsr image wrong");
    a_ri_image: assert property ($stable(modem_in.ri) [*4] ##0 st_rd |-> prdata[UMS_B_RI] == modem_in.ri)
        else $error("ri image wrong");
    a_cts_set: assert property ($changed(modem_in.cts) ##1 !st_rd [*6] ##[1:2] st_rd |-> prdata[UMS_B_CLEAR_TO_SEND_CHANGE_FLAG])
        else $error("cts change not flagged");
    a_cts_clear: assert property ($stable(modem_in.cts) [*8] ##0 (st_rd && $past(st_rd, 3)) |-> !prdata[UMS_B_CLEAR_TO_SEND_CHANGE_FLAG])
        else $error("cts flag not cleared by read");
    a_nack_cause: assert property (nack_out |-> $past(rx_evt.char_done) && $past(rx_evt.parity_err))
        else $error("non-ack without parity error");
    a_nack_pulse: assert property (nack_out |=> !nack_out)
        else $error("non-ack longer than a cycle");
endmodule
bind ums_status ums_chk #(.TX_IDLE_CYCLES(TX_IDLE_CYCLES)) chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modem_in(modem_in), .rx_evt(rx_evt), .nack_out(nack_out));

// ### verification/ums_modem.sv
// Partner model: modem driving the modem-control lines
`timescale 1ns/1ps
module ums_modem (
    input wire logic pclk,
    output ums_pkg::ums_modem_t lines
);
    import ums_pkg::*;
    // Lines rest low until commanded
    initial lines = '0;
    // Flip one line after an edge and hold it
    task automatic toggle(input int idx);
        @(posedge pclk);
        lines[idx] <= ~lines[idx];
    endtask
endmodule

// ### verification/ums_status_tb.sv
// Testbench: scenarios for the modem status flag block
`timescale 1ns/1ps
module ums_status_tb;
    import ums_pkg::*;
    // Short idle time keeps the run brief
    localparam int TXI = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nack_out, irq, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    ums_modem_t modem_w;
    ums_rx_evt_t rx_evt;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    ums_status #(.TX_IDLE_CYCLES(TXI)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .modem_in(modem_w), .rx_evt(rx_evt), .nack_out(nack_out), .irq(irq));
    ums_modem mdm (.pclk(pclk), .lines(modem_w));
    always #2.5 pclk = ~pclk;
    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            finish_test();
        end
    end
    ////////////////////////////////////////
    task automatic finish_test();
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rs(input string nm, input logic [31:0] e);
        apb(1'h0, UMS_OFF_STATUS, 32'h0);
        chk(nm, e, rdat);
    endtask
    // Expected status with live line images
    function automatic logic [31:0] st(input logic [31:0] f);
        return f | {10'h0, modem_w.dsr, modem_w.ri, 20'h0};
    endfunction
    // One received character, then the non-ack pulse
    task automatic ch(input logic pe, input logic en);
        @(posedge pclk);
        rx_evt <= {1'h1, pe};
        @(posedge pclk);
        rx_evt <= 2'h0;
        @(negedge pclk);
        chk("nack", {31'h0, en}, {31'h0, nack_out});
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        rs("reset", 32'h200);
        apb(1'h0, UMS_OFF_IMR, 32'h0);
        chk("mask", 32'h0, rdat);
        apb(1'h0, 8'h18, 32'h0);
        chk("unmapped", 32'h1, {31'h0, rerr});
        apb(1'h1, UMS_OFF_STATUS, 32'hffff_ffff);
        rs("ro", 32'h200);
    endtask
    task automatic t_modem();
        for (int i = 0; i < 4; i++) begin
            mdm.toggle(i);
            repeat (5) @(posedge pclk);
            rs("flag", st(32'h200 | (32'h1 << (16 + i))));
            rs("once", st(32'h200));
        end
    endtask
    // Change lands on the clearing read
    task automatic t_race();
        mdm.toggle(3);
        apb(1'h0, UMS_OFF_STATUS, 32'h0);
        repeat (5) @(posedge pclk);
        rs("kept", st(32'h8_0200));
    endtask
    task automatic t_irq();
        apb(1'h1, UMS_OFF_IMR, 32'h1_0000);
        mdm.toggle(1);
        repeat (6) @(negedge pclk);
        chk("masked", 32'h0, {31'h0, irq});
        mdm.toggle(0);
        repeat (6) @(negedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'h1, UMS_OFF_EVT, 32'h3_0000);
        apb(1'h0, UMS_OFF_STATUS, 32'h0);
        repeat (2) @(negedge pclk);
        chk("irq off", 32'h0, {31'h0, irq});
    endtask
    task automatic t_card();
        apb(1'h1, UMS_OFF_MODE, 32'h0220_0000);
        ch(1'h1, 1'h1);
        ch(1'h1, 1'h1);
        ch(1'h1, 1'h0);
        rs("limit", st(32'h2600));
        apb(1'h1, UMS_OFF_CTRL, 32'h8000);
        rs("rep clr", st(32'h2200));
        apb(1'h1, UMS_OFF_CTRL, 32'h4000);
        rs("nack clr", st(32'h200));
        ch(1'h0, 1'h0);
        ch(1'h1, 1'h1);
        apb(1'h1, UMS_OFF_MODE, 32'h0010_0000);
        ch(1'h1, 1'h0);
        apb(1'h1, UMS_OFF_MODE, 32'h0);
        ch(1'h1, 1'h1);
    endtask
    task automatic t_tx();
        apb(1'h1, UMS_OFF_THR, 32'h55);
        rs("tx busy", st(32'h2000));
        repeat (TXI) @(posedge pclk);
        rs("tx idle", st(32'h2200));
    endtask
    ////////////////////////////////////////
    initial begin
        pclk = 1'h0;
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        rx_evt = 2'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_modem();
        t_race();
        t_irq();
        t_card();
        t_tx();
        finish_test();
    end
endmodule
